// ---- verilog/sar_adc_device.sv ----
/*
 Converter end: successive approximation sequencing, serial readout and power-down control.
 Assumes trigger and serial clock arrive synchronous to the system clock, and that the
 sampled analog input is presented as a digital code on sample_value.
*/
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module sar_adc_device #(
	parameter int WIDTH = `ADC_WIDTH
) (
	input wire logic clock,
	input wire logic reset,
	sar_adc_link_if.device link,
	input wire logic [WIDTH-1:0] sample_value,
	input wire logic bipolar_mode,
	input wire logic reference_low,
	output logic [WIDTH-1:0] last_result,
	output logic result_strobe,
	output logic converting,
	output logic napping,
	output logic sleeping,
	output logic unresponsive
);

	localparam int LAST_BIT_EDGE = 2 * WIDTH + 1;
	localparam int END_EDGE = 2 * WIDTH + 2;
	localparam int EW = $clog2(END_EDGE + 1);

	sar_adc_pkg::dev_state_type state_r;
	logic sclk_prev_r;
	logic trig_prev_r;
	logic [7:0] high_cnt_r;
	logic [2:0] pd_cnt_r;
	logic [EW-1:0] edge_r;
	logic [WIDTH-1:0] bit_search_register;
	logic [WIDTH-1:0] target_r;
	logic bipolar_r;
	logic [WIDTH:0] shift_r;
	logic [WIDTH-1:0] last_result_r;
	logic result_strobe_r;
	logic data_out_r;
	logic data_oe_r;

	logic sclk_rise;
	logic sclk_fall;
	logic trig_rise;
	logic wide_pulse;
	logic [2:0] pd_cnt_inc;
	logic running;
	logic [WIDTH-1:0] bit_mask;
	logic [WIDTH-1:0] trial;
	logic [WIDTH-1:0] decided;
	logic reference_settled_flag;

	// Offset binary inside the search, two's complement outside it in bipolar mode.
	function automatic logic [WIDTH-1:0] offset_flip(input logic [WIDTH-1:0] code, input logic bip);
		offset_flip = bip ? {~code[WIDTH-1], code[WIDTH-2:0]} : code;
	endfunction

	assign sclk_rise = link.serial_clock & ~sclk_prev_r;
	assign sclk_fall = ~link.serial_clock & sclk_prev_r;
	assign trig_rise = link.sample_trigger & ~trig_prev_r;
	assign wide_pulse = high_cnt_r >= 8'(`WAKE_PULSE_CYC);
	assign pd_cnt_inc = pd_cnt_r + 3'h1;
	assign running = (state_r == sar_adc_pkg::DEV_ARMED) || (state_r == sar_adc_pkg::DEV_CONVERT);
	assign reference_settled_flag = ~reference_low;

	// The trial bit walks down from the top one position per serial clock rise.
	assign bit_mask = {1'b1, {(WIDTH - 1){1'b0}}} >> edge_r;
	assign trial = bit_search_register | bit_mask;
	assign decided = (trial <= target_r) ? trial : bit_search_register;

	always_ff @(posedge clock) begin
		if (reset) begin
			sclk_prev_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			sclk_prev_r <= link.serial_clock;
			trig_prev_r <= link.sample_trigger;
		end
	end

	// Width of the current clock high time, judged when the clock falls.
	always_ff @(posedge clock) begin
		if (reset) begin
			high_cnt_r <= 8'h00;
		end else if (!link.serial_clock) begin
			high_cnt_r <= 8'h00;
		end else if (high_cnt_r != 8'hFF) begin
			high_cnt_r <= high_cnt_r + 8'h01;
		end
	end

	// Only an unbroken run of pulses under a low clock counts toward power-down.
	always_ff @(posedge clock) begin
		if (reset) begin
			pd_cnt_r <= 3'h0;
		end else if (link.serial_clock) begin
			pd_cnt_r <= 3'h0;
		end else if (trig_rise && pd_cnt_r != 3'h7) begin
			pd_cnt_r <= pd_cnt_inc;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= sar_adc_pkg::DEV_IDLE;
		end else begin
			unique case (state_r)
				sar_adc_pkg::DEV_IDLE: begin
					if (trig_rise) begin
						state_r <= sar_adc_pkg::DEV_ARMED;
					end
				end
				sar_adc_pkg::DEV_ARMED: begin
					// A second pulse before any clock is a power-down request, not a restart.
					if (sclk_rise) begin
						state_r <= sar_adc_pkg::DEV_CONVERT;
					end else if (trig_rise && pd_cnt_inc == `NAP_PULSES) begin
						state_r <= sar_adc_pkg::DEV_NAP;
					end
				end
				sar_adc_pkg::DEV_CONVERT: begin
					// Triggers are not looked at here, so a running conversion never restarts.
					if (sclk_rise && edge_r == EW'(END_EDGE - 1)) begin
						state_r <= sar_adc_pkg::DEV_IDLE;
					end
				end
				sar_adc_pkg::DEV_NAP: begin
					if (sclk_fall) begin
						state_r <= wide_pulse ? sar_adc_pkg::DEV_IDLE : sar_adc_pkg::DEV_STUCK;
					end else if (trig_rise && pd_cnt_inc == `SLEEP_PULSES) begin
						state_r <= sar_adc_pkg::DEV_SLEEP;
					end
				end
				sar_adc_pkg::DEV_SLEEP: begin
					if (sclk_fall) begin
						state_r <= wide_pulse ? sar_adc_pkg::DEV_IDLE : sar_adc_pkg::DEV_STUCK;
					end
				end
				sar_adc_pkg::DEV_STUCK: begin
					// Conversion requests go unanswered until a nap request comes in.
					if (trig_rise && pd_cnt_inc == `NAP_PULSES) begin
						state_r <= sar_adc_pkg::DEV_NAP;
					end
				end
				default: begin
					state_r <= sar_adc_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// Counts clock rises since the conversion began; the idle state parks it at zero.
	always_ff @(posedge clock) begin
		if (reset) begin
			edge_r <= '0;
		end else if (state_r == sar_adc_pkg::DEV_IDLE) begin
			edge_r <= '0;
		end else if (running && sclk_rise) begin
			edge_r <= edge_r + EW'(1);
		end
	end

	// The input code is frozen at the start so later changes cannot disturb the search.
	always_ff @(posedge clock) begin
		if (reset) begin
			bit_search_register <= '0;
			target_r <= '0;
			bipolar_r <= 1'b0;
		end else if (state_r == sar_adc_pkg::DEV_IDLE && trig_rise) begin
			bit_search_register <= '0;
			target_r <= offset_flip(sample_value, bipolar_mode);
			bipolar_r <= bipolar_mode;
		end else if (running && sclk_rise && edge_r < EW'(WIDTH)) begin
			bit_search_register <= decided;
		end
	end

	// On the last decision the finished word is taken for output.
	always_ff @(posedge clock) begin
		if (reset) begin
			last_result_r <= '0;
			result_strobe_r <= 1'b0;
		end else if (running && sclk_rise && edge_r == EW'(WIDTH - 1)) begin
			last_result_r <= offset_flip(decided, bipolar_r);
			result_strobe_r <= 1'b1;
		end else begin
			result_strobe_r <= 1'b0;
		end
	end

	// Flag goes out first, then the result from its top bit down.
	always_ff @(posedge clock) begin
		if (reset) begin
			shift_r <= '0;
			data_out_r <= 1'b0;
			data_oe_r <= 1'b0;
		end else if (running && sclk_rise) begin
			if (edge_r == EW'(WIDTH - 1)) begin
				shift_r <= {reference_settled_flag, offset_flip(decided, bipolar_r)};
			end else if (edge_r >= EW'(WIDTH) && edge_r < EW'(LAST_BIT_EDGE)) begin
				data_out_r <= shift_r[`FLAG_POS];
				data_oe_r <= 1'b1;
				shift_r <= {shift_r[WIDTH-1:0], 1'b0};
			end else if (edge_r == EW'(END_EDGE - 1)) begin
				data_out_r <= 1'b0;
				data_oe_r <= 1'b0;
			end
		end
	end

	assign link.serial_data_out = data_out_r;
	assign link.serial_data_oe = data_oe_r;
	assign last_result = last_result_r;
	assign result_strobe = result_strobe_r;
	assign converting = running;
	assign napping = state_r == sar_adc_pkg::DEV_NAP;
	assign sleeping = state_r == sar_adc_pkg::DEV_SLEEP;
	assign unresponsive = state_r == sar_adc_pkg::DEV_STUCK;

endmodule // sar_adc_device

// ---- verilog/sar_adc_regs.svh ----
/*
 Timing counts, pulse counts and field positions for the converter control link.
 Assumes a 100 MHz system clock; every cycle count below is derived from that period.
*/
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define ADC_WIDTH 12
`define CLOCK_PERIOD_NS 10

// Least serial clock pulse that wakes the converter, rounded up.
`define WAKE_PULSE_NS 50
`define WAKE_PULSE_CYC ((`WAKE_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Least trigger pulse width, rounded up.
`define TRIG_PULSE_NS 50
`define TRIG_PULSE_CYC ((`TRIG_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Longest early trigger high time, rounded down.
`define TRIG_RELEASE_NS 120
`define TRIG_RELEASE_CYC (`TRIG_RELEASE_NS / `CLOCK_PERIOD_NS)

// Least time from trigger rise to first serial clock rise, rounded up.
`define TRIG_SETUP_NS 80
`define TRIG_SETUP_CYC ((`TRIG_SETUP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Serial clock half period, rounded up, keeping the rate below 6.4 MHz.
`define SCLK_HALF_NS 80
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Serial clock edge after which a late trigger release is safe.
`define LATE_RELEASE_CLOCKS 14

// Trigger pulses under a low clock for each low-power state.
`define NAP_PULSES 3'h2
`define SLEEP_PULSES 3'h4

// Position of the settled flag in the serial word, above the result bits.
`define FLAG_POS `ADC_WIDTH

`endif

// ---- verilog/sar_adc_pkg.sv ----
/*
 State types shared by both ends of the converter link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sar_adc_pkg;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_ARMED = 3'h1,
		DEV_CONVERT = 3'h2,
		DEV_NAP = 3'h3,
		DEV_SLEEP = 3'h4,
		DEV_STUCK = 3'h5
	} dev_state_type;

	typedef enum logic [2:0] {
		HOST_IDLE = 3'h0,
		HOST_TRIG = 3'h1,
		HOST_SETUP = 3'h2,
		HOST_CLOCK = 3'h3,
		HOST_PD_HIGH = 3'h4,
		HOST_PD_LOW = 3'h5,
		HOST_WAKE = 3'h6
	} host_state_type;

endpackage

// ---- verilog/sar_adc_link_if.sv ----
/*
 Three-wire link between the converter and its host.
 Assumes both ends run on the same system clock; the data wire is resolved here.
*/
`timescale 1ns/1ps

interface sar_adc_link_if;
	logic sample_trigger;
	logic serial_clock;
	logic serial_data_out;
	logic serial_data_oe;
	logic serial_data;

	// There is no pull on the wire, so a released wire reads as the inverse of serial_data_out, which the converter clears to 0 on release.
	// A host that samples it outside the word then sees a wrong bit rather than a stale one.
	assign serial_data = serial_data_oe ? serial_data_out : ~serial_data_out;

	modport device (
		input sample_trigger,
		input serial_clock,
		output serial_data_out,
		output serial_data_oe
	);

	modport host (
		output sample_trigger,
		output serial_clock,
		input serial_data
	);
endinterface

// ---- verilog/sar_adc_host.sv ----
/*
 Host end: generates trigger and serial clock, collects the serial word, and issues
 nap, sleep and wake sequences.
 Assumes the converter end shares the system clock.
*/
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module sar_adc_host #(
	parameter int WIDTH = `ADC_WIDTH
) (
	input wire logic clock,
	input wire logic reset,
	sar_adc_link_if.host link,
	input wire logic start,
	input wire logic nap_req,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic ready,
	output logic [WIDTH-1:0] result,
	output logic settled,
	output logic result_valid
);

	localparam int LAST_BIT_EDGE = 2 * WIDTH + 1;
	localparam int END_EDGE = 2 * WIDTH + 2;
	localparam int EW = $clog2(END_EDGE + 1);

	sar_adc_pkg::host_state_type state_r;
	logic [7:0] timer_r;
	logic [EW-1:0] edges_r;
	logic [2:0] pulses_r;
	logic [2:0] goal_r;
	logic sclk_r;
	logic trig_r;
	logic [WIDTH:0] shift_in_r;
	logic [WIDTH-1:0] result_r;
	logic settled_r;
	logic valid_r;
	logic timer_done;

	assign timer_done = timer_r == 8'h00;

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= sar_adc_pkg::HOST_IDLE;
			timer_r <= 8'h00;
			edges_r <= '0;
			pulses_r <= 3'h0;
			goal_r <= 3'h0;
			sclk_r <= 1'b0;
			trig_r <= 1'b0;
			shift_in_r <= '0;
		end else begin
			if (!timer_done) begin
				timer_r <= timer_r - 8'h01;
			end
			unique case (state_r)
				sar_adc_pkg::HOST_IDLE: begin
					pulses_r <= 3'h0;
					if (start) begin
						trig_r <= 1'b1;
						timer_r <= 8'(`TRIG_PULSE_CYC - 1);
						state_r <= sar_adc_pkg::HOST_TRIG;
					end else if (nap_req || sleep_req) begin
						// A nap request is also how a stalled converter is brought back.
						goal_r <= sleep_req ? `SLEEP_PULSES : `NAP_PULSES;
						trig_r <= 1'b1;
						timer_r <= 8'(`TRIG_PULSE_CYC - 1);
						state_r <= sar_adc_pkg::HOST_PD_HIGH;
					end else if (wake_req) begin
						sclk_r <= 1'b1;
						timer_r <= 8'(`SCLK_HALF_CYC - 1);
						state_r <= sar_adc_pkg::HOST_WAKE;
					end
				end
				sar_adc_pkg::HOST_TRIG: begin
					// Released well before the first decision, so no bit is disturbed.
					if (timer_done) begin
						trig_r <= 1'b0;
						timer_r <= 8'(`TRIG_SETUP_CYC - 1);
						state_r <= sar_adc_pkg::HOST_SETUP;
					end
				end
				sar_adc_pkg::HOST_SETUP: begin
					if (timer_done) begin
						sclk_r <= 1'b1;
						edges_r <= EW'(1);
						timer_r <= 8'(`SCLK_HALF_CYC - 1);
						state_r <= sar_adc_pkg::HOST_CLOCK;
					end
				end
				sar_adc_pkg::HOST_CLOCK: begin
					if (timer_done) begin
						timer_r <= 8'(`SCLK_HALF_CYC - 1);
						if (sclk_r) begin
							// Sample on the falling edge, half a period after the bit changed.
							sclk_r <= 1'b0;
							if (edges_r > EW'(WIDTH) && edges_r <= EW'(LAST_BIT_EDGE)) begin
								shift_in_r <= {shift_in_r[WIDTH-1:0], link.serial_data};
							end
							if (edges_r == EW'(END_EDGE)) begin
								state_r <= sar_adc_pkg::HOST_IDLE;
							end
						end else begin
							sclk_r <= 1'b1;
							edges_r <= edges_r + EW'(1);
						end
					end
				end
				sar_adc_pkg::HOST_PD_HIGH: begin
					if (timer_done) begin
						trig_r <= 1'b0;
						pulses_r <= pulses_r + 3'h1;
						timer_r <= 8'(`TRIG_PULSE_CYC - 1);
						state_r <= sar_adc_pkg::HOST_PD_LOW;
					end
				end
				sar_adc_pkg::HOST_PD_LOW: begin
					// The clock stays low across the whole burst so every pulse counts.
					if (timer_done) begin
						if (pulses_r == goal_r) begin
							state_r <= sar_adc_pkg::HOST_IDLE;
						end else begin
							trig_r <= 1'b1;
							timer_r <= 8'(`TRIG_PULSE_CYC - 1);
							state_r <= sar_adc_pkg::HOST_PD_HIGH;
						end
					end
				end
				sar_adc_pkg::HOST_WAKE: begin
					if (timer_done) begin
						sclk_r <= 1'b0;
						state_r <= sar_adc_pkg::HOST_IDLE;
					end
				end
				default: begin
					state_r <= sar_adc_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			result_r <= '0;
			settled_r <= 1'b0;
			valid_r <= 1'b0;
		end else if (state_r == sar_adc_pkg::HOST_CLOCK && timer_done && sclk_r && edges_r == EW'(END_EDGE)) begin
			result_r <= shift_in_r[WIDTH-1:0];
			settled_r <= shift_in_r[`FLAG_POS];
			valid_r <= 1'b1;
		end else begin
			valid_r <= 1'b0;
		end
	end

	assign link.sample_trigger = trig_r;
	assign link.serial_clock = sclk_r;
	assign ready = state_r == sar_adc_pkg::HOST_IDLE;
	assign result = result_r;
	assign settled = settled_r;
	assign result_valid = valid_r;

endmodule // sar_adc_host

// ---- tb/sar_adc_link_sva.sv ----
/*
 Checker for the three-wire converter link between the host end and the converter end.
 Assumes it is instantiated beside the interface, on the system clock and its synchronous reset.
*/
`timescale 1ns/1ps

module sar_adc_link_sva (
	input wire logic clock,
	input wire logic reset,
	input wire logic sample_trigger,
	input wire logic serial_clock,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// The converter answers one cycle after it sees a serial clock rise.
	sequence s_rise_seen;
		$past(serial_clock) && !$past(serial_clock, 2);
	endsequence

	sequence s_trig_pulse;
		sample_trigger[*5] ##1 !sample_trigger;
	endsequence

	property p_oe_rise;
		$rose(serial_data_oe) |-> s_rise_seen;
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("Data pin driven without a clock rise.");

	property p_data_step;
		(serial_data_oe && $changed(serial_data_out)) |-> s_rise_seen;
	endproperty
	a_data_step: assert property (p_data_step) else $error("Data bit moved without a clock rise.");

	property p_oe_fall;
		$fell(serial_data_oe) |-> s_rise_seen;
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("Data pin released without a clock rise.");

	property p_oe_hold;
		$rose(serial_data_oe) |-> serial_data_oe[*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("Data pin released inside the word.");

	property p_oe_quiet;
		$fell(serial_data_oe) |-> !serial_data_oe[*8];
	endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("Data pin driven again too soon.");

	property p_sclk_width;
		$rose(serial_clock) |-> serial_clock[*8] ##1 !serial_clock;
	endproperty
	a_sclk_width: assert property (p_sclk_width) else $error("Serial clock high time wrong.");

	property p_trig_width;
		$rose(sample_trigger) |-> s_trig_pulse;
	endproperty
	a_trig_width: assert property (p_trig_width) else $error("Trigger pulse width wrong.");

	property p_trig_setup;
		$rose(sample_trigger) |-> !serial_clock[*8];
	endproperty
	a_trig_setup: assert property (p_trig_setup) else $error("Serial clock rose too soon after trigger.");

	property p_trig_clock_low;
		$rose(sample_trigger) |-> !serial_clock;
	endproperty
	a_trig_clock_low: assert property (p_trig_clock_low) else $error("Trigger raised with clock high.");
endmodule // sar_adc_link_sva

// ---- tb/testbench.sv ----
/*
 Testbench: host and converter ends joined by one link, plus a second converter driven directly.
 Assumes a 100 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ps

module testbench;
	logic clock, reset, start, nap_req, sleep_req, wake_req;
	logic bipolar_mode, reference_low, ready, settled, result_valid;
	logic [11:0] sample_value, result, last_result, last_result2;
	logic conv1, nap1, sleep1, stuck1, conv2, nap2, sleep2, stuck2;
	logic strobe1;
	logic [12:0] word;
	logic [11:0] values [6] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5A, 12'h001};
	int fails, n_tests, strobes;

	sar_adc_link_if link();
	sar_adc_link_if link2();

	sar_adc_host sar_adc_host_inst (.clock, .reset, .link(link), .start, .nap_req, .sleep_req, .wake_req,
		.ready, .result, .settled, .result_valid);
	sar_adc_device sar_adc_device_inst (.clock, .reset, .link(link), .sample_value, .bipolar_mode,
		.reference_low, .last_result, .result_strobe(strobe1), .converting(conv1), .napping(nap1),
		.sleeping(sleep1), .unresponsive(stuck1));
	// The second converter faces the bench so that rule breaking on the wire can be staged.
	sar_adc_device sar_adc_device_inst2 (.clock, .reset, .link(link2), .sample_value, .bipolar_mode,
		.reference_low, .last_result(last_result2), .result_strobe(), .converting(conv2),
		.napping(nap2), .sleeping(sleep2), .unresponsive(stuck2));
	sar_adc_link_sva sar_adc_link_sva_inst (.clock(clock), .reset(reset), .sample_trigger(link.sample_trigger),
		.serial_clock(link.serial_clock), .serial_data_out(link.serial_data_out),
		.serial_data_oe(link.serial_data_oe));

	// Bits are taken on the falling clock, half a period after the converter moved them.
	// A trigger rise clears the word; the trigger is always low again by the first fall.
	always @(posedge link.sample_trigger or negedge link.serial_clock) begin
		if (link.sample_trigger) begin
			word <= 13'h0000;
		end else if (link.serial_data_oe) begin
			word <= {word[11:0], link.serial_data};
		end
	end
	always @(negedge clock) begin
		if (strobe1 === 1'h1) begin
			strobes++;
		end
	end

	task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (ready !== 1'h1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		check("ready", {12'h000, ready}, 13'h0001);
	endtask

	task automatic host_req(input int k);
		wait_ready();
		start = (k == 0);
		nap_req = (k == 1);
		sleep_req = (k == 2);
		wake_req = (k == 3);
		@(negedge clock);
		{start, nap_req, sleep_req, wake_req} = 4'h0;
		@(negedge clock);
	endtask

	task automatic power(input int k);
		host_req(k);
		wait_ready();
		repeat (2) @(negedge clock);
	endtask

	task automatic convert(input logic [11:0] v, input logic b, input logic rl);
		int n;
		int s0;
		sample_value = v;
		bipolar_mode = b;
		reference_low = rl;
		s0 = strobes;
		host_req(0);
		check("converting", {12'h000, conv1}, 13'h0001);
		n = 0;
		while (result_valid !== 1'h1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		check("valid", {12'h000, result_valid}, 13'h0001);
		check("strobe", 13'(strobes - s0), 13'h0001);
		check("result", {1'h0, result}, {1'h0, v});
		check("last_result", {1'h0, last_result}, {1'h0, v});
		check("settled", {12'h000, settled}, {12'h000, ~rl});
		check("wire word", word, {~rl, v});
		check("released", {12'h000, link.serial_data_oe}, 13'h0000);
	endtask

	task automatic trig_pulse;
		link2.sample_trigger = 1'h1;
		repeat (5) @(negedge clock);
		link2.sample_trigger = 1'h0;
		repeat (5) @(negedge clock);
	endtask

	task automatic clk_pulse(input int w);
		link2.serial_clock = 1'h1;
		repeat (w) @(negedge clock);
		link2.serial_clock = 1'h0;
		repeat (8) @(negedge clock);
	endtask

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		complete_run();
	end

	initial begin
		reset = 1'h1;
		{start, nap_req, sleep_req, wake_req} = 4'h0;
		sample_value = 12'h000;
		bipolar_mode = 1'h0;
		reference_low = 1'h0;
		link2.sample_trigger = 1'h0;
		link2.serial_clock = 1'h0;
		fails = 0;
		n_tests = 0;
		strobes = 0;
		repeat (20) @(negedge clock);
		reset = 1'h0;
		check("idle oe", {12'h000, link.serial_data_oe}, 13'h0000);
		foreach (values[i]) begin
			convert(values[i], 1'h0, 1'h0);
		end
		check("unipolar", {1'h0, last_result}, 13'h0001);
		convert(12'h800, 1'h1, 1'h0);
		check("bipolar", {1'h0, last_result}, 13'h0800);
		convert(12'hFFF, 1'h1, 1'h0);
		convert(12'h3C3, 1'h0, 1'h1);
		power(1);
		check("nap", {12'h000, nap1}, 13'h0001);
		power(3);
		check("nap woken", {12'h000, nap1}, 13'h0000);
		power(2);
		check("sleep", {12'h000, sleep1}, 13'h0001);
		power(3);
		check("sleep woken", {12'h000, sleep1}, 13'h0000);
		check("awake1", {11'h000, conv1, stuck1}, 13'h0000);
		convert(12'h123, 1'h0, 1'h0);
		sample_value = 12'hA5C;
		trig_pulse();
		for (int i = 1; i <= 26; i++) begin
			clk_pulse(8);
			// A late trigger after clock 14 keeps the release timing legal; a new code shows a restart.
			if (i == 14) begin
				sample_value = 12'h35A;
				trig_pulse();
			end
		end
		check("no restart", {1'h0, last_result2}, 13'h0A5C);
		check("idle after", {12'h000, conv2}, 13'h0000);
		trig_pulse();
		trig_pulse();
		check("nap2", {12'h000, nap2}, 13'h0001);
		clk_pulse(4);
		check("stuck", {12'h000, stuck2}, 13'h0001);
		trig_pulse();
		check("ignored", {12'h000, conv2}, 13'h0000);
		trig_pulse();
		check("recovered", {12'h000, nap2}, 13'h0001);
		trig_pulse();
		trig_pulse();
		check("sleep2", {12'h000, sleep2}, 13'h0001);
		clk_pulse(5);
		check("woken2", {11'h000, sleep2, stuck2}, 13'h0000);
		complete_run();
	end
endmodule // testbench
